// File: src/wake_sync_pkg.sv
// Package for the wake-up enable and slow-clock synchronisation slice.
// Assumes a byte-wide register port from the die-to-die link, single clock.
package wake_sync_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [11:0] BLOCKING_BASE = 12'h200;
    localparam logic [11:0] NONBLOCKING_BASE = 12'h300;
    localparam logic [7:0] OFS_MILLISECOND_PRESCALER_HIGH = 8'h04;
    localparam logic [7:0] OFS_MILLISECOND_PRESCALER_LOW = 8'h05;
    localparam logic [7:0] OFS_WAKE_HIGH = 8'h06;
    localparam logic [7:0] OFS_WAKE_LOW = 8'h07;
    localparam logic [7:0] OFS_PFACTOR = 8'h08;
    localparam logic [7:0] OFS_WAKE_FLAGS = 8'h09;
    localparam logic [7:0] OFS_TRIM_HIGH = 8'h0e;
    localparam logic [7:0] OFS_TRIM_LOW = 8'h0f;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int LIFETIME_EN_BIT = 7;
    localparam int READY_BIT = 7;
    localparam logic [15:0] MILLISECOND_PRESCALER_RESET = 16'h7d00;
    localparam logic [12:0] SLOW_MILLISECOND_PRESCALER_INIT = 13'h0200;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] PFACTOR_RESET = 2'h0;

    // Cycles the slow divider must run before the value is accepted.
    localparam int SYNC_CYCLES_DEFAULT = 64;

    // Wake-up enables, one per source, in high-byte bit order.
    typedef struct packed {
        logic wake_on_charge_count_en;
        logic wake_on_current_limit_en;
        logic wake_on_recal_request_en;
        logic wake_on_bus_activity_en;
        logic [3:0] wake_on_input_en;
    } wake_high_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic blocking;
        logic [11:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [2:0] {
        SYNC_IDLE = 3'b001,
        SYNC_RUN = 3'b010,
        SYNC_DONE = 3'b100
    } sync_state_t;

endpackage

// File: src/wake_sync.sv
// Wake-up enable registers, wake flags and slow-clock prescaler sync.
// Assumes the link delivers single-cycle byte requests synchronous to
// ref_clk and that wake events and low_power_mode are synchronous too.
`timescale 1ns/10ps
`default_nettype none
module wake_sync
    import wake_sync_pkg::*;
#(
    parameter int SYNC_CYCLES = SYNC_CYCLES_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire reg_req_t req,
    output logic [7:0] rdata,
    output logic ack,
    input wire logic low_power_mode,
    input wire logic [8:0] wake_event,
    input wire logic [12:0] measured_prescaler,
    output logic wake_request,
    output logic lifetime_clk_en,
    output logic timer_clk_en,
    output logic trigger_clk_en,
    output logic [15:0] millisecond_prescaler,
    output logic [1:0] prescaler_factor
);

    // The sync counter is 13 bits wide but only up to 4096 cycles are allowed, and a zero count
    // would wrap the end of a sync to count 8191, so both are refused here.
    if (SYNC_CYCLES < 1 || SYNC_CYCLES > 4096) begin : gen_bad_sync_cycles
        $error("SYNC_CYCLES out of range");
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic hit;
    logic [7:0] ofs;
    logic wr_hit;
    logic [11:0] base_sel;
    assign base_sel = req.blocking ? BLOCKING_BASE : NONBLOCKING_BASE;
    assign hit = (req.addr[11:8] == base_sel[11:8]);
    assign ofs = req.addr[7:0];
    assign wr_hit = req.wr && hit;
    assign ack = (req.wr || req.rd) && hit;

    wake_high_t wake_high_reg;
    logic wake_low_reg;
    logic [15:0] millisecond_prescaler_reg;
    logic [7:0] millisecond_prescaler_hold_reg;
    logic [1:0] pfactor_reg;
    logic [8:0] flags_reg;
    logic [12:0] slow_value_reg;
    logic ready_reg;
    sync_state_t state_reg;
    logic [12:0] sync_cnt_reg;
    logic [12:0] div_cnt_reg;
    logic changed;
    logic [8:0] enables;
    logic [8:0] hits;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_high_reg <= '0;
            wake_low_reg <= 1'b0;
        end else if (wr_hit && ofs == OFS_WAKE_HIGH) begin
            wake_high_reg <= req.wdata;
        end else if (wr_hit && ofs == OFS_WAKE_LOW) begin
            wake_low_reg <= req.wdata[LIFETIME_EN_BIT];
        end
    end

    // The high byte is held until the low byte lands, so the divider never
    // sees a half-updated word.
    // whole-word prescaler update
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            millisecond_prescaler_reg <= MILLISECOND_PRESCALER_RESET;
            millisecond_prescaler_hold_reg <= MILLISECOND_PRESCALER_RESET[15:8];
        end else if (wr_hit && ofs == OFS_MILLISECOND_PRESCALER_HIGH) begin
            millisecond_prescaler_hold_reg <= req.wdata;
        end else if (wr_hit && ofs == OFS_MILLISECOND_PRESCALER_LOW) begin
            millisecond_prescaler_reg <= {millisecond_prescaler_hold_reg, req.wdata};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pfactor_reg <= PFACTOR_RESET;
        end else if (wr_hit && ofs == OFS_PFACTOR) begin
            pfactor_reg <= req.wdata[1:0];
        end
    end

    assign millisecond_prescaler = millisecond_prescaler_reg;
    assign prescaler_factor = pfactor_reg;

    // ------------------------------------------------------------------
    // Wake logic
    // ------------------------------------------------------------------
    // enable gating
    assign enables = {wake_low_reg, wake_high_reg};
    assign hits = wake_event & enables & {9{low_power_mode}};
    assign wake_request = |hits;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= '0;
        end else if (wr_hit && ofs == OFS_WAKE_FLAGS) begin
            flags_reg <= (flags_reg & ~{1'b0, req.wdata}) | hits;
        end else begin
            flags_reg <= flags_reg | hits;
        end
    end

    // ------------------------------------------------------------------
    // Slow prescaler synchronisation
    // ------------------------------------------------------------------
    // change restarts sync
    assign changed = wr_hit && (ofs == OFS_MILLISECOND_PRESCALER_LOW || ofs == OFS_PFACTOR);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SYNC_IDLE;
            sync_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (changed) begin
            state_reg <= SYNC_RUN;
            sync_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                SYNC_IDLE: begin
                    state_reg <= SYNC_RUN;
                end
                SYNC_RUN: begin
                    if (sync_cnt_reg == 13'(SYNC_CYCLES - 1)) begin
                        state_reg <= SYNC_DONE;
                        ready_reg <= 1'b1;
                    end else begin
                        sync_cnt_reg <= sync_cnt_reg + 13'h0001;
                    end
                end
                SYNC_DONE: begin
                    ready_reg <= 1'b1;
                end
                default: begin
                    state_reg <= SYNC_IDLE;
                end
            endcase
        end
    end

    // Only the first sync uses the forced value; later restarts keep the
    // last accepted value so the lifetime counter does not jump meanwhile.
    // forced initial value
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            slow_value_reg <= SLOW_MILLISECOND_PRESCALER_INIT;
        end else if (state_reg == SYNC_RUN && sync_cnt_reg == 13'(SYNC_CYCLES - 1)
                     && !changed) begin
            slow_value_reg <= measured_prescaler;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_reg <= '0;
        end else if (div_cnt_reg >= slow_value_reg) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 13'h0001;
        end
    end

    logic tick;
    assign tick = ready_reg && (div_cnt_reg >= slow_value_reg);
    assign lifetime_clk_en = tick;
    assign timer_clk_en = tick && low_power_mode;
    assign trigger_clk_en = tick && low_power_mode;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= BYTE_ZERO;
        end else if (req.rd && hit) begin
            unique case (ofs)
                OFS_MILLISECOND_PRESCALER_HIGH: rdata <= millisecond_prescaler_reg[15:8];
                OFS_MILLISECOND_PRESCALER_LOW: rdata <= millisecond_prescaler_reg[7:0];
                OFS_WAKE_HIGH: rdata <= wake_high_reg;
                OFS_WAKE_LOW: rdata <= {wake_low_reg, 7'h00};
                OFS_PFACTOR: rdata <= {6'h00, pfactor_reg};
                OFS_WAKE_FLAGS: rdata <= flags_reg[7:0];
                OFS_TRIM_HIGH: rdata <= {ready_reg, 2'h0, slow_value_reg[12:8]};
                OFS_TRIM_LOW: rdata <= slow_value_reg[7:0];
                default: rdata <= BYTE_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Helper for the initial-value check. It remembers that the first sync
    // has completed, after which a restart may keep an older value.
    logic first_sync_done_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            first_sync_done_reg <= 1'b0;
        end else if (ready_reg) begin
            first_sync_done_reg <= 1'b1;
        end
    end

    AST_CHARGE_WAKE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (low_power_mode && wake_event[7] && !wake_high_reg.wake_on_charge_count_en)
        |-> !hits[7]) else $error("charge wake while disabled");
    AST_CURRENT_WAKE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (low_power_mode && wake_event[6] && wake_high_reg.wake_on_current_limit_en)
        |-> wake_request) else $error("current wake missing");
    AST_RECAL_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
        (hits[5]) |=> flags_reg[5]) else $error("recal flag not set");
    AST_BUS_WAKE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wake_event[4] && !wake_high_reg.wake_on_bus_activity_en) |-> !hits[4])
        else $error("bus wake while disabled");
    AST_LOW_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req.rd && hit && ofs == OFS_WAKE_LOW) |=> rdata[6:0] == 7'h00)
        else $error("low enable bits not zero");
    AST_READY_DROP: assert property (@(posedge ref_clk) disable iff (!rstn)
        changed |=> !ready_reg) else $error("ready did not drop");
    AST_READY_TIME: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(ready_reg) |-> $past(state_reg) == SYNC_RUN)
        else $error("ready rose outside sync");
    AST_INIT_HELD: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!first_sync_done_reg && !ready_reg) |-> slow_value_reg == SLOW_MILLISECOND_PRESCALER_INIT)
        else $error("initial value not held");
    AST_NO_FLAG_MASKED: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!flags_reg[0] && !wake_high_reg.wake_on_input_en[0] && !wr_hit) |=> !flags_reg[0])
        else $error("masked source set flag");
    AST_TIMER_LP: assert property (@(posedge ref_clk) disable iff (!rstn)
        timer_clk_en |-> (low_power_mode && lifetime_clk_en))
        else $error("timer tick outside low power");
    // The following checks cover the register side (decode, stores and clears), then tick gating and the held sync value.
    AST_BASE_MISS: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req.blocking && req.addr[11:8] != BLOCKING_BASE[11:8]) |-> !ack)
        else $error("ack on foreign base");
    AST_ENABLE_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_hit && ofs == OFS_WAKE_HIGH) |=> wake_high_reg == $past(req.wdata))
        else $error("enable byte not stored");
    AST_MILLISECOND_PRESCALER_HALF: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_hit && ofs == OFS_MILLISECOND_PRESCALER_HIGH) |=> $stable(millisecond_prescaler_reg))
        else $error("prescaler changed on half word");
    AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_hit && ofs == OFS_WAKE_FLAGS && req.wdata[0] && !hits[0]) |=> !flags_reg[0])
        else $error("flag not cleared");
    AST_TICK_READY: assert property (@(posedge ref_clk) disable iff (!rstn)
        lifetime_clk_en |-> ready_reg)
        else $error("tick before sync");
    AST_TRIGGER_LP: assert property (@(posedge ref_clk) disable iff (!rstn)
        trigger_clk_en |-> low_power_mode)
        else $error("trigger tick outside low power");
    AST_VALUE_HELD: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_reg == SYNC_DONE && !changed) |=> $stable(slow_value_reg))
        else $error("value moved after sync");

    COV_WAKE: cover property (@(posedge ref_clk) disable iff (!rstn) wake_request);
    COV_SYNC: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(ready_reg));
    COV_RESYNC: cover property (@(posedge ref_clk) disable iff (!rstn) ready_reg && changed);
    COV_CLEAR: cover property (@(posedge ref_clk) disable iff (!rstn)
        wr_hit && ofs == OFS_WAKE_FLAGS && |flags_reg);
    COV_LP_TICK: cover property (@(posedge ref_clk) disable iff (!rstn) timer_clk_en);

endmodule
`default_nettype wire

// File: test/mcu_link_model.sv
// Model of the controller die driving byte requests over the die-to-die link.
// Assumes the block answers with ack in the request cycle and rdata one cycle later.
`timescale 1ns/10ps
`default_nettype none
module mcu_link_model
    import wake_sync_pkg::*;
(
    input wire logic ref_clk,
    input wire logic ack,
    input wire logic [7:0] rdata,
    output var reg_req_t req
);
    initial begin
        req = '0;
    end

    // ------------------------------------------------------------------
    // Single byte access
    // ------------------------------------------------------------------
    // The request stands for exactly one cycle, because ack does not wait.
    task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic k);
        @(posedge ref_clk);
        req <= '{wr: w, rd: !w, blocking: (a[11:8] != 4'h3), addr: a, wdata: d};
        @(negedge ref_clk);
        k = ack;
        @(posedge ref_clk);
        req <= '0;
        @(negedge ref_clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// File: test/test_wake_sync.sv
// Self-checking bench for the wake-up enable and slow prescaler slice.
// Assumes a shortened sync count so that each resync takes a few cycles.
`timescale 1ns/10ps
`default_nettype none
module test_wake_sync;
    import wake_sync_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic low_power_mode = 1'b0;
    logic [8:0] wake_event = 9'h000;
    logic [12:0] measured_prescaler = 13'h1234;
    reg_req_t req;
    logic [7:0] rdata, q;
    logic ack, k, wake_request, lifetime_clk_en, timer_clk_en, trigger_clk_en;
    logic [15:0] millisecond_prescaler;
    logic [1:0] prescaler_factor;
    int n_errors = 0;
    int num_checks = 0;
    int lt, tm;

    wake_sync #(.SYNC_CYCLES(16)) i_wake_sync (.ref_clk(ref_clk), .rstn(rstn), .req(req),
        .rdata(rdata), .ack(ack), .low_power_mode(low_power_mode), .wake_event(wake_event),
        .measured_prescaler(measured_prescaler), .wake_request(wake_request),
        .lifetime_clk_en(lifetime_clk_en), .timer_clk_en(timer_clk_en),
        .trigger_clk_en(trigger_clk_en), .millisecond_prescaler(millisecond_prescaler),
        .prescaler_factor(prescaler_factor));
    mcu_link_model i_mcu_link_model (.ref_clk(ref_clk), .ack(ack), .rdata(rdata), .req(req));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        i_mcu_link_model.access(1'b0, a, 8'h00, q, k);
        chk(16'(k), 16'h0001);
        chk(16'(q), 16'(e));
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_mcu_link_model.access(1'b1, a, d, q, k);
    endtask

    // Polls the ready flag; a hang counts as a mismatch and ends the run.
    task automatic wait_ready();
        for (int n = 0; n < 100; n++) begin
            i_mcu_link_model.access(1'b0, 12'h20e, 8'h00, q, k);
            if (q[7] === 1'b1) begin
                return;
            end
        end
        n_errors++;
        $display("mismatch at %0t got %h exp %h", $time, q[7], 1'b1);
        end_of_test();
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(12'h20e, 8'h02);
        rd(12'h20f, 8'h00);
        rd(12'h206, 8'h00);
        rd(12'h307, 8'h00);
        chk(millisecond_prescaler, MILLISECOND_PRESCALER_RESET);
        wait_ready();
        rd(12'h20e, 8'h92);
        rd(12'h20f, 8'h34);
        wr(12'h306, 8'ha5);
        rd(12'h206, 8'ha5);
        wr(12'h207, 8'hff);
        rd(12'h307, 8'h80);
        wr(12'h106, 8'h3c);
        chk(16'(k), 16'h0000);
        rd(12'h206, 8'ha5);
        @(posedge ref_clk);
        low_power_mode <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            wr(12'h206, e ? 8'hff : 8'h00);
            wr(12'h207, e ? 8'h80 : 8'h00);
            for (int i = 0; i < 9; i++) begin
                @(posedge ref_clk);
                wake_event <= 9'h001 << i;
                @(negedge ref_clk);
                chk(16'(wake_request), 16'(e));
                @(posedge ref_clk);
                wake_event <= 9'h000;
                rd(12'h209, (e && i < 8) ? 8'h01 << i : 8'h00);
                wr(12'h209, 8'hff);
                rd(12'h209, 8'h00);
            end
        end
        @(posedge ref_clk);
        low_power_mode <= 1'b0;
        wr(12'h204, 8'h12);
        wr(12'h205, 8'h34);
        chk(millisecond_prescaler, 16'h1234);
        wr(12'h204, 8'h56);
        chk(millisecond_prescaler, 16'h1234);
        rd(12'h204, 8'h12);
        rd(12'h20e, 8'h12);
        wait_ready();
        @(posedge ref_clk);
        measured_prescaler <= 13'h0007;
        wr(12'h308, 8'h03);
        chk(16'(prescaler_factor), 16'h0003);
        rd(12'h20e, 8'h12);
        wait_ready();
        rd(12'h20f, 8'h07);
        for (int m = 0; m < 2; m++) begin
            lt = 0;
            tm = 0;
            @(posedge ref_clk);
            low_power_mode <= m[0];
            repeat (40) begin
                @(negedge ref_clk);
                lt += lifetime_clk_en;
                tm += timer_clk_en + trigger_clk_en;
            end
            chk(16'(lt >= 4 && lt <= 6), 16'h0001);
            chk(16'(tm > 0), 16'(m[0]));
        end
        // A second power-up must drop the enables and force the initial value.
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(12'h20e, 8'h02);
        rd(12'h206, 8'h00);
        rd(12'h307, 8'h00);
        rd(12'h209, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
